// >>> hw/led_matrix_scanner.sv
// Host-side 3x3 status LED matrix scanner with AXI4-Lite registers
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module led_matrix_scanner #(
    parameter int unsigned ROW_SLOT_CYCLES = led_scan_pkg::ROW_SLOT_CYCLES
) (
    // Clock and reset
    input  wire logic                                clk_sys,
    input  wire logic                                rst,
    // AXI4-Lite write address
    input  wire logic [led_scan_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [led_scan_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                              s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    // Channel state from the power side link
    input  wire logic [7:0]                          channel_drive,
    input  wire logic [7:0]                          led_gate_flag,
    input  wire logic [7:0]                          channel_overtemp,
    input  wire logic [7:0]                          channel_overcurrent,
    // Device state
    input  wire logic                                err_n,
    input  wire logic                                host_mode_serial,
    input  wire logic                                hw_reset_pin_n,
    output logic                                     hw_reset_req,
    // Shared bus pins: normal bus function in, pin drive out
    input  wire logic [led_scan_pkg::PINS-1:0]       bus_out,
    input  wire logic [led_scan_pkg::PINS-1:0]       bus_oe,
    output logic [led_scan_pkg::PINS-1:0]            pin_o,
    output logic [led_scan_pkg::PINS-1:0]            pin_oe,
    // Matrix lines, active high
    output logic                                     led_column_out_0,
    output logic                                     led_column_out_1,
    output logic                                     led_column_out_2,
    output logic                                     led_row_out_0,
    output logic                                     led_row_out_1,
    output logic                                     led_row_out_2
);
    import led_scan_pkg::*;

    // ************************************************************
    // Register bus
    // ************************************************************
    logic                  aw_got_ff;
    logic                  nxt_aw_got;
    logic [AXI_ADDR_W-1:0] awaddr_ff;
    logic [AXI_ADDR_W-1:0] nxt_awaddr;
    logic                  w_got_ff;
    logic                  nxt_w_got;
    logic [31:0]           wdata_ff;
    logic [31:0]           nxt_wdata;
    logic [3:0]            wstrb_ff;
    logic [3:0]            nxt_wstrb;
    logic                  bvalid_ff;
    logic                  nxt_bvalid;
    logic [1:0]            bresp_ff;
    logic [1:0]            nxt_bresp;
    logic                  rvalid_ff;
    logic                  nxt_rvalid;
    logic [31:0]           rdata_ff;
    logic [31:0]           nxt_rdata;
    logic [1:0]            rresp_ff;
    logic [1:0]            nxt_rresp;
    logic                  cfg_enable_ff;
    logic                  nxt_cfg_enable;

    logic                  aw_now;
    logic                  w_now;
    logic [AXI_ADDR_W-1:0] waddr_now;
    logic [31:0]           wdata_now;
    logic [3:0]            wstrb_now;
    logic [31:0]           status_word;

    logic                  matrix_on;
    logic [8:0]            lit9;
    logic [2:0]            row_ff;
    logic [2:0]            col_ff;

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready  = !w_got_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;

    always_comb begin
        aw_now         = aw_got_ff || (s_axi_awvalid && s_axi_awready);
        w_now          = w_got_ff || (s_axi_wvalid && s_axi_wready);
        waddr_now      = aw_got_ff ? awaddr_ff : s_axi_awaddr;
        wdata_now      = w_got_ff ? wdata_ff : s_axi_wdata;
        wstrb_now      = w_got_ff ? wstrb_ff : s_axi_wstrb;
        nxt_aw_got     = aw_now;
        nxt_awaddr     = waddr_now;
        nxt_w_got      = w_now;
        nxt_wdata      = wdata_now;
        nxt_wstrb      = wstrb_now;
        nxt_bvalid     = bvalid_ff && !s_axi_bready;
        nxt_bresp      = bresp_ff;
        nxt_cfg_enable = cfg_enable_ff;
        if (aw_now && w_now && !bvalid_ff) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = RESP_OKAY;
            if (waddr_now[AXI_ADDR_W-1:2] == OFF_CONFIG[AXI_ADDR_W-1:2]) begin
                if (wstrb_now[0]) begin
                    nxt_cfg_enable = wdata_now[CFG_ENABLE_BIT];
                end
            end else if (waddr_now[AXI_ADDR_W-1:2] != OFF_STATUS[AXI_ADDR_W-1:2]) begin
                nxt_bresp = RESP_SLVERR;
            end
        end
    end

    always_comb begin
        status_word                      = '0;
        status_word[ST_ROW_LSB +: 3]     = row_ff;
        status_word[ST_COL_LSB +: 3]     = col_ff;
        status_word[ST_ON_BIT]           = matrix_on;
        status_word[ST_LIT_LSB +: 8]     = lit9[7:0];
        status_word[ST_ERR_BIT]          = lit9[ERR_POS];
        nxt_rvalid = rvalid_ff && !s_axi_rready;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            if (s_axi_araddr[AXI_ADDR_W-1:2] == OFF_CONFIG[AXI_ADDR_W-1:2]) begin
                nxt_rdata = {31'h0, cfg_enable_ff};
            end else if (s_axi_araddr[AXI_ADDR_W-1:2] == OFF_STATUS[AXI_ADDR_W-1:2]) begin
                nxt_rdata = status_word;
            end else begin
                nxt_rdata = 32'h0;
                nxt_rresp = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_got_ff     <= 1'b0;
            awaddr_ff     <= '0;
            w_got_ff      <= 1'b0;
            wdata_ff      <= 32'h0;
            wstrb_ff      <= 4'h0;
            bvalid_ff     <= 1'b0;
            bresp_ff      <= RESP_OKAY;
            rvalid_ff     <= 1'b0;
            rdata_ff      <= 32'h0;
            rresp_ff      <= RESP_OKAY;
            cfg_enable_ff <= CFG_ENABLE_RST;
        end else begin
            aw_got_ff     <= nxt_aw_got;
            awaddr_ff     <= nxt_awaddr;
            w_got_ff      <= nxt_w_got;
            wdata_ff      <= nxt_wdata;
            wstrb_ff      <= nxt_wstrb;
            bvalid_ff     <= nxt_bvalid;
            bresp_ff      <= nxt_bresp;
            rvalid_ff     <= nxt_rvalid;
            rdata_ff      <= nxt_rdata;
            rresp_ff      <= nxt_rresp;
            cfg_enable_ff <= nxt_cfg_enable;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // ************************************************************
    // Row scan and fault hold
    // ************************************************************
    scan_if scan ();

    row_scan_timer #(
        .SLOT_CYCLES (ROW_SLOT_CYCLES)
    ) u_timer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .scan    (scan)
    );

    assign matrix_on = cfg_enable_ff && host_mode_serial;
    assign scan.run  = matrix_on;

    logic [HOLD_W-1:0] hold_ff [CHANNELS];
    logic [HOLD_W-1:0] nxt_hold [CHANNELS];
    logic [7:0]        hold_busy;
    logic [7:0]        fault_vec;

    assign fault_vec = channel_overtemp | channel_overcurrent;

    // Hold counts whole scans; it freezes while the matrix is off, which only lengthens it
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            nxt_hold[i]  = hold_ff[i];
            hold_busy[i] = (hold_ff[i] != '0);
            if (!led_gate_flag[i] || fault_vec[i]) begin
                nxt_hold[i] = HOLD_W'(GATE_HOLD_SCANS);
            end else if (scan.frame_tick && hold_busy[i]) begin
                nxt_hold[i] = hold_ff[i] - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < CHANNELS; i++) begin
                hold_ff[i] <= '0;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                hold_ff[i] <= nxt_hold[i];
            end
        end
    end

    // Channel n sits at position n, error at position 8
    assign lit9 = {!err_n,
                   channel_drive & led_gate_flag & ~fault_vec & ~hold_busy};

    // ************************************************************
    // Matrix and pin drive
    // ************************************************************
    logic [2:0]      nxt_row_o;
    logic [2:0]      nxt_col_o;
    logic [PINS-1:0] pin_o_ff;
    logic [PINS-1:0] nxt_pin_o;
    logic [PINS-1:0] pin_oe_ff;
    logic [PINS-1:0] nxt_pin_oe;
    logic            hw_reset_ff;
    logic            nxt_hw_reset;
    logic [8:0]      lit_ff;

    always_comb begin
        nxt_row_o    = 3'h0;
        nxt_col_o    = 3'h0;
        nxt_pin_o    = bus_out;
        nxt_pin_oe   = bus_oe;
        if (matrix_on) begin
            nxt_row_o  = scan.row;
            nxt_col_o  = col_pattern(row_index(scan.row), lit9);
            nxt_pin_o  = {nxt_row_o[0], nxt_row_o[1], nxt_row_o[2],
                          nxt_col_o[0], nxt_col_o[1], nxt_col_o[2]};
            nxt_pin_oe = {PINS{1'b1}};
        end
        // Reset pin doubles as a column line while enabled
        nxt_hw_reset = !cfg_enable_ff && !hw_reset_pin_n;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            row_ff      <= 3'h0;
            col_ff      <= 3'h0;
            pin_o_ff    <= '0;
            pin_oe_ff   <= '0;
            hw_reset_ff <= 1'b0;
            lit_ff      <= 9'h0;
        end else begin
            row_ff      <= nxt_row_o;
            col_ff      <= nxt_col_o;
            pin_o_ff    <= nxt_pin_o;
            pin_oe_ff   <= nxt_pin_oe;
            hw_reset_ff <= nxt_hw_reset;
            lit_ff      <= lit9;
        end
    end

    assign pin_o            = pin_o_ff;
    assign pin_oe           = pin_oe_ff;
    assign hw_reset_req     = hw_reset_ff;
    assign led_row_out_0    = row_ff[0];
    assign led_row_out_1    = row_ff[1];
    assign led_row_out_2    = row_ff[2];
    assign led_column_out_0 = col_ff[0];
    assign led_column_out_1 = col_ff[1];
    assign led_column_out_2 = col_ff[2];

    property p_pins_owned;
        @(posedge clk_sys) disable iff (rst)
        matrix_on |=> (pin_oe == 6'h3f && pin_o[5] == led_row_out_0 && pin_o[2] == led_column_out_0);
    endproperty
    a_pins_owned: assert property (p_pins_owned) else $error("matrix pins not taken over");

    property p_dark_off;
        @(posedge clk_sys) disable iff (rst)
        !cfg_enable_ff |=> (row_ff == 3'h0 && col_ff == 3'h0);
    endproperty
    a_dark_off: assert property (p_dark_off) else $error("matrix driven while disabled");

    property p_dark_parallel;
        @(posedge clk_sys) disable iff (rst)
        !host_mode_serial |=> (row_ff == 3'h0 && pin_oe == $past(bus_oe));
    endproperty
    a_dark_parallel: assert property (p_dark_parallel) else $error("matrix driven outside serial mode");

    property p_reset_masked;
        @(posedge clk_sys) disable iff (rst)
        (cfg_enable_ff || hw_reset_pin_n) |=> !hw_reset_req;
    endproperty
    a_reset_masked: assert property (p_reset_masked) else $error("reset pin honoured while enabled");

    property p_one_row;
        @(posedge clk_sys) disable iff (rst)
        $onehot0(row_ff) && (!$past(matrix_on) || $onehot(row_ff));
    endproperty
    a_one_row: assert property (p_one_row) else $error("more or fewer than one row active");

    property p_fault_dark;
        @(posedge clk_sys) disable iff (rst)
        1'b1 |=> ((lit_ff[7:0] & $past(fault_vec)) == 8'h0);
    endproperty
    a_fault_dark: assert property (p_fault_dark) else $error("faulted channel lit");

    property p_err_pos;
        @(posedge clk_sys) disable iff (rst)
        (matrix_on && !err_n && scan.row == ROW2) |=> led_column_out_2;
    endproperty
    a_err_pos: assert property (p_err_pos) else $error("error position not lit");

    property p_hold_dark;
        @(posedge clk_sys) disable iff (rst)
        (!led_gate_flag[0] || fault_vec[0]) ##1 (led_gate_flag[0] && !fault_vec[0])
            |-> (hold_ff[0] == HOLD_W'(GATE_HOLD_SCANS) && !lit9[0]);
    endproperty
    a_hold_dark: assert property (p_hold_dark) else $error("fault hold not started");

    property p_col_map;
        @(posedge clk_sys) disable iff (rst)
        matrix_on |=> (col_ff == col_pattern(row_index($past(scan.row)), $past(lit9)));
    endproperty
    a_col_map: assert property (p_col_map) else $error("columns do not match active row");

endmodule
`default_nettype wire

// >>> hw/led_scan_pkg.sv
// Constants, types and helpers shared by the host-side LED matrix scanner
// Overview of operation
// - Matrix on: six bus pins become columns/rows
// - Drive matrix only while enable bit set
// - Matrix works only in serial host mode
// - Enable bit set masks hardware reset pin
// - Three-by-three matrix, one position per channel
// - Lit only if active, no overtemp/overcurrent
// - Ninth position shows the error indicator
// - Rows in turn, one third each, 1000 Hz
// - Drive gated by flag; dark 100 ms after fault
`default_nettype none
package led_scan_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned SCAN_HZ         = 1000;
    localparam int unsigned ROWS            = 3;
    localparam int unsigned ROW_SLOT_CYCLES = CLK_HZ / (SCAN_HZ * ROWS);
    localparam int unsigned SCAN_PERIOD_US  = 1_000_000 / SCAN_HZ;
    localparam int unsigned GATE_HOLD_MS    = 100;
    // Plus one scan: the first scan after a fault may be partial
    localparam int unsigned GATE_HOLD_SCANS =
        (GATE_HOLD_MS * 1000 + SCAN_PERIOD_US - 1) / SCAN_PERIOD_US + 1;
    localparam int unsigned HOLD_W          = 7;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned AXI_ADDR_W      = 8;
    localparam logic [7:0]  OFF_CONFIG      = 8'h00;
    localparam logic [7:0]  OFF_STATUS      = 8'h04;
    localparam int unsigned CFG_ENABLE_BIT  = 0;
    localparam logic        CFG_ENABLE_RST  = 1'b0;
    localparam int unsigned ST_ROW_LSB      = 0;
    localparam int unsigned ST_COL_LSB      = 3;
    localparam int unsigned ST_ON_BIT       = 6;
    localparam int unsigned ST_LIT_LSB      = 8;
    localparam int unsigned ST_ERR_BIT      = 16;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    // ************************************************************
    // Matrix layout
    // ************************************************************
    localparam int unsigned CHANNELS        = 8;
    localparam int unsigned ERR_POS         = 8;
    // Pin vector order: bus_pin_1, ALE/reset, WR, bus_pin_2, bus_pin_3, bus_pin_6
    localparam int unsigned PINS            = 6;

    typedef enum logic [2:0] {
        ROW0 = 3'b001,
        ROW1 = 3'b010,
        ROW2 = 3'b100
    } row_e;

    function automatic logic [1:0] row_index(input row_e r);
        unique case (r)
            ROW0: row_index = 2'd0;
            ROW1: row_index = 2'd1;
            ROW2: row_index = 2'd2;
            default: row_index = 2'd0;
        endcase
    endfunction

    // Position = row*3 + column; bit c of the result is column c
    function automatic logic [2:0] col_pattern(input logic [1:0] r, input logic [8:0] lit);
        unique case (r)
            2'd0: col_pattern = lit[2:0];
            2'd1: col_pattern = lit[5:3];
            default: col_pattern = lit[8:6];
        endcase
    endfunction

endpackage
`default_nettype wire

// >>> hw/row_scan_timer.sv
// Row slot divider: steps the active row and marks each full scan
`timescale 1ns/100ps
`default_nettype none
module row_scan_timer #(
    parameter int unsigned SLOT_CYCLES = led_scan_pkg::ROW_SLOT_CYCLES
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Scan signals
    scan_if.timer     scan
);
    import led_scan_pkg::*;

    localparam int unsigned CW = (SLOT_CYCLES < 2) ? 1 : $clog2(SLOT_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(SLOT_CYCLES - 1);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    row_e          row_ff;
    row_e          nxt_row;
    logic          slot_ff;
    logic          nxt_slot;
    logic          frame_ff;
    logic          nxt_frame;

    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_row   = row_ff;
        nxt_slot  = 1'b0;
        nxt_frame = 1'b0;
        if (!scan.run) begin
            nxt_cnt = '0;
            nxt_row = ROW0;
        end else if (cnt_ff == LAST) begin
            nxt_cnt  = '0;
            nxt_slot = 1'b1;
            unique case (row_ff)
                ROW0: nxt_row = ROW1;
                ROW1: nxt_row = ROW2;
                ROW2: begin
                    nxt_row   = ROW0;
                    nxt_frame = 1'b1;
                end
                default: nxt_row = ROW0;
            endcase
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_ff   <= '0;
            row_ff   <= ROW0;
            slot_ff  <= 1'b0;
            frame_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            row_ff   <= nxt_row;
            slot_ff  <= nxt_slot;
            frame_ff <= nxt_frame;
        end
    end

    assign scan.row        = row_ff;
    assign scan.slot_start = slot_ff;
    assign scan.frame_tick = frame_ff;

    property p_row_advance;
        @(posedge clk_sys) disable iff (rst)
        (scan.run && cnt_ff == LAST && row_ff == ROW1) |=> (row_ff == ROW2 && slot_ff && cnt_ff == '0);
    endproperty
    a_row_advance: assert property (p_row_advance) else $error("row did not advance at slot end");

    property p_frame_wrap;
        @(posedge clk_sys) disable iff (rst)
        frame_ff |-> (row_ff == ROW0 && slot_ff && $past(row_ff) == ROW2);
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("scan tick without wrap from last row");

endmodule
`default_nettype wire

// >>> hw/scan_if.sv
// Row scan signals between the scan timer and the matrix scanner
`timescale 1ns/100ps
`default_nettype none
interface scan_if;
    import led_scan_pkg::*;
    logic run;
    row_e row;
    logic slot_start;
    logic frame_tick;
    modport timer (input run, output row, output slot_start, output frame_tick);
    modport user  (output run, input row, input slot_start, input frame_tick);
endinterface
`default_nettype wire

// >>> verif/host_side_led_matrix_scanner_tb_top.sv
// Self-checking bench for the host-side LED matrix scanner
`timescale 1ns/100ps
`default_nettype none
module host_side_led_matrix_scanner_tb_top;
    import led_scan_pkg::*;
    localparam int SLOT = 4;
    logic        clk_sys = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic        awr, wr, bv, arr, rv, rreq, err_n = 1'h1, serial = 1'h0, rpin_n = 1'h1;
    logic [7:0]  awa = 8'h0, ara = 8'h0, drive = 8'h0, gate = 8'hff, ot = 8'h0, oc = 8'h0;
    logic [31:0] wd = 32'h0, rd, d;
    logic [1:0]  bresp, rresp, resp;
    logic [5:0]  bus_out = 6'h2a, bus_oe = 6'h15, pin_o, pin_oe;
    wire  [2:0]  row, col;
    logic [8:0]  seen;
    int          n_mismatch = 0, cmp_count = 0, cyc = 0, seed = 32'hfa125514;

    always #10 clk_sys = ~clk_sys;

    led_matrix_scanner #(.ROW_SLOT_CYCLES(SLOT)) dut (.clk_sys(clk_sys), .rst(rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .channel_drive(drive), .led_gate_flag(gate),
        .channel_overtemp(ot), .channel_overcurrent(oc), .err_n(err_n), .host_mode_serial(serial),
        .hw_reset_pin_n(rpin_n), .hw_reset_req(rreq), .bus_out(bus_out), .bus_oe(bus_oe), .pin_o(pin_o),
        .pin_oe(pin_oe), .led_column_out_0(col[0]), .led_column_out_1(col[1]), .led_column_out_2(col[2]),
        .led_row_out_0(row[0]), .led_row_out_1(row[1]), .led_row_out_2(row[2]));
    led_matrix_model mx (.clk_sys(clk_sys), .row_on(row), .col_on(col), .seen(seen));

    // ************************************************************
    // Checks, bus cycles and closing
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge clk_sys);
        awa <= a; wd <= v; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (awv && awr) awv <= 1'h0;
            if (wv && wr) wv <= 1'h0;
        end while (!((awv && awr || !awv) && (wv && wr || !wv)));
        while (bv !== 1'h1) @(posedge clk_sys);
        r = bresp;
        bry <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk_sys);
        ara <= a; arv <= 1'h1; rry <= 1'h1;
        do @(posedge clk_sys); while (arr !== 1'h1);
        arv <= 1'h0;
        do @(posedge clk_sys); while (rv !== 1'h1);
        v = rd; r = rresp;
        rry <= 1'h0;
    endtask
    // One full scan: total and row 0 time, one-hot rows, pin sharing
    task automatic scan(input bit on, input string nm);
        int n[3];
        int bad;
        n = '{0, 0, 0}; bad = 0;
        repeat (3 * SLOT) begin
            @(posedge clk_sys); #1;
            for (int i = 0; i < 3; i++) n[i] += row[i];
            if ($countones(row) > 1) bad++;
            if (on && (pin_o !== {row[0], row[1], row[2], col[0], col[1], col[2]} || pin_oe !== 6'h3f)) bad++;
            if (!on && (pin_o !== bus_out || pin_oe !== bus_oe)) bad++;
        end
        chk(nm, on ? SLOT * 3 : 0, n[0] + n[1] + n[2]);
        chk("row0", on ? SLOT : 0, n[0]);
        chk("pins", 0, bad);
        // Return on a rising edge so the next stimulus lands there
        @(posedge clk_sys);
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'h0;
        rd_reg(OFF_CONFIG, d, resp);
        chk("cfg_reset", 32'h0, d);
        rd_reg(8'h40, d, resp);
        chk("rd_unmapped", RESP_SLVERR, resp);
        wr_reg(8'h40, 32'h1, resp);
        chk("wr_unmapped", RESP_SLVERR, resp);
        $display("test registers done");
        rpin_n <= 1'h0;
        wr_reg(OFF_CONFIG, 32'h1, resp);
        scan(0, "parallel_rows");
        chk("rst_masked", 1'h0, rreq);
        serial <= 1'h1;
        repeat (5) begin
            drive <= 8'($random(seed));
            err_n <= 1'($random(seed));
            repeat (3) scan(1, "serial_rows");
            chk("lit", {~err_n, drive}, seen);
        end
        $display("test scan done");
        drive <= 8'hff; err_n <= 1'h1; ot <= 8'h01; oc <= 8'h02; gate <= 8'hfb;
        repeat (2) @(posedge clk_sys);
        ot <= 8'h0; oc <= 8'h0; gate <= 8'hff;
        repeat (90 * 3 * SLOT) @(posedge clk_sys);
        chk("held_dark", 9'h0f8, seen);
        repeat (15 * 3 * SLOT) @(posedge clk_sys);
        chk("relit", 9'h0ff, seen);
        rd_reg(OFF_STATUS, d, resp);
        chk("status_resp", RESP_OKAY, resp);
        chk("status", 32'h0000ff40, d & 32'h0001ff40);
        chk("status_row", 32'h1, $countones(d[2:0]));
        $display("test fault hold done");
        wr_reg(OFF_CONFIG, 32'h0, resp);
        scan(0, "disabled_rows");
        chk("rst_honoured", 1'h1, rreq);
        $display("test disable done");
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> verif/led_matrix_model.sv
// External 3x3 LED matrix: records which positions glowed in each row slot
`timescale 1ns/100ps
`default_nettype none
module led_matrix_model (
    // Clock
    input  wire logic       clk_sys,
    // Matrix lines, active high
    input  wire logic [2:0] row_on,
    input  wire logic [2:0] col_on,
    // Last seen state of the nine LEDs
    output logic      [8:0] seen
);
    initial seen = 9'h0;
    // Two rows at once would smear: both rows take the same columns, as on a real board
    always @(posedge clk_sys) begin
        for (int r = 0; r < 3; r++) begin
            if (row_on[r]) begin
                for (int c = 0; c < 3; c++) begin
                    seen[r*3+c] <= col_on[c];
                end
            end
        end
    end
endmodule
`default_nettype wire
